/* File: include/fpe_pkg.sv */
// Package for the flash program/erase control block: offsets, fields, codes.
// Assumes a 32-bit APB register bus and one 100 MHz system clock.
package fpe_pkg;

  // Register byte offsets
  localparam logic [7:0] FPE_OFS_CONTROL = 8'h00;
  localparam logic [7:0] FPE_OFS_KEY     = 8'h04;
  localparam logic [7:0] FPE_OFS_TARGET  = 8'h08;
  localparam logic [7:0] FPE_OFS_PWORD   = 8'h0C;
  localparam logic [7:0] FPE_OFS_ROWSRC  = 8'h10;

  // flash_op_control field positions
  localparam int FPE_BIT_TRIGGER = 15;
  localparam int FPE_BIT_WRITE_ENABLE_GATE    = 14;
  localparam int FPE_BIT_SEQERR  = 13;
  localparam int FPE_BIT_LVERR   = 12;
  localparam int FPE_BIT_LVSTAT  = 11;
  localparam int FPE_OP_LSB      = 0;
  localparam int FPE_OP_MSB      = 3;

  // Values after power-on reset
  localparam logic [31:0] FPE_RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  FPE_RST_OP   = 4'h0;

  // Operation codes
  localparam logic [3:0] FPE_OP_NOP       = 4'h0;
  localparam logic [3:0] FPE_OP_WORD_PROG = 4'h1;
  localparam logic [3:0] FPE_OP_ROW_PROG  = 4'h3;
  localparam logic [3:0] FPE_OP_PAGE_ERASE = 4'h4;
  localparam logic [3:0] FPE_OP_ARRAY_ERASE = 4'h5;

  // Unlock progress
  localparam logic [1:0] FPE_KEY_NONE  = 2'h0;
  localparam logic [1:0] FPE_KEY_FIRST = 2'h1;
  localparam logic [1:0] FPE_KEY_OPEN  = 2'h2;

  typedef enum logic [1:0] {
    FPE_IDLE = 2'b00,
    FPE_RUN  = 2'b01,
    FPE_FIN  = 2'b10
  } fpe_state_type;

  typedef struct packed {
    fpe_state_type state;
    logic          trigger;
    logic          seq_err;
    logic          lv_err;
    logic [3:0]    op_code;
    logic [31:0]   target_addr;
    logic [31:0]   program_word;
    logic [31:0]   row_src;
    logic [1:0]    key_stage;
    logic [31:0]   rdata;
    logic          start;
    logic          lv_s1;
    logic          lv_s2;
  } fpe_regs_type;

endpackage

/* File: src/fpe_flash_ctrl.sv */
// Flash program/erase control: APB register file plus operation sequencer.
// Assumes the flash macro answers on clk_i; low-voltage input is asynchronous.
//
// Summary of operation
// [R1] Trigger bit sets only with write enable gate high and unlock completed.
// [R2] Writing trigger starts operation; trigger stays high until hardware clears it.
// [R3] Write enable gate allows trigger writes and powers the low-voltage detector.
// [R4] Device reset clears only the write enable gate; other bits keep value.
// [R5] Sequence error flag sets when program or erase fails; read only.
// [R6] Low-voltage error flag sets on low supply while detector is enabled.
// [R7] Live low-voltage status follows the detector while it is enabled.
// [R8] Flags clear only by triggering operation code zero.
// [R9] Operation code field is writable only while write enable gate is low.
// [R10] Code 0101 erases whole array unless any page is protected.
// [R11] Code 0100 erases addressed page unless that page is protected.
// [R12] Code 0011 programs addressed row unless that row is protected.
// [R13] Code 0001 programs addressed word unless its location is protected.
// [R14] Unlock key register is write only and reads as zero.
// [R15] Key writes feed the unlock check that guards every operation start.
// [R16] Unimplemented control bits read zero and ignore writes.
// [R17] Array erase ignores target address; other operations use it.
// [R18] Row programming fetches data from the row source address.
// [R19] Program word register clears only on power-on reset.
// [R20] No-operation and reserved codes change no flash, then clear trigger.
`timescale 1ns/100ps
module fpe_flash_ctrl
  import fpe_pkg::*;
#(
  parameter logic [31:0] UNLOCK_KEY_FIRST  = 32'h1234_5678, // Arbitrary value
  parameter logic [31:0] UNLOCK_KEY_SECOND = 32'h8765_4321  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        low_voltage_i,
  input  wire logic        page_protected_i,
  input  wire logic        any_protected_i,
  input  wire logic        flash_done_i,
  input  wire logic        flash_fail_i,
  output logic             flash_start_o,
  output logic      [3:0]  flash_op_o,
  output logic      [31:0] flash_addr_o,
  output logic      [31:0] flash_data_o,
  output logic      [31:0] row_source_address_o,
  output logic             detector_enable_o
);

  fpe_regs_type q;
  fpe_regs_type d;
  logic         write_enable_gate_q;
  logic         write_enable_gate_d;
  logic         acc_wr;
  logic         lv_act;
  logic         rd_setup;
  logic         blocked_chk;

  function automatic logic fpe_real_op(input logic [3:0] op);
    fpe_real_op = (op == FPE_OP_WORD_PROG) || (op == FPE_OP_ROW_PROG) ||
                  (op == FPE_OP_PAGE_ERASE) || (op == FPE_OP_ARRAY_ERASE);
  endfunction

  function automatic logic fpe_mapped(input logic [31:0] a);
    fpe_mapped = (a[31:8] == 24'h00_0000) &&
                 ((a[7:0] == FPE_OFS_CONTROL) || (a[7:0] == FPE_OFS_KEY) ||
                  (a[7:0] == FPE_OFS_TARGET) || (a[7:0] == FPE_OFS_PWORD) ||
                  (a[7:0] == FPE_OFS_ROWSRC));
  endfunction

  assign acc_wr = psel_i && penable_i && pwrite_i;
  assign lv_act = write_enable_gate_q && q.lv_s2;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  // Same scope choice as the sequencer, kept apart for the assertions
  assign blocked_chk = (q.op_code == FPE_OP_ARRAY_ERASE) ? any_protected_i : page_protected_i;

  always_comb begin
    logic [31:0] ctl;
    logic        blocked;
    d         = q;
    ctl       = 32'h0000_0000;
    blocked   = 1'b0;
    write_enable_gate_d    = write_enable_gate_q;
    d.start   = 1'b0;
    // Detector level comes from the analog side, so two flops before any use
    d.lv_s1   = low_voltage_i;
    d.lv_s2   = q.lv_s1;
    // Unimplemented positions stay zero in the readback word
    ctl[FPE_BIT_TRIGGER]         = q.trigger;
    ctl[FPE_BIT_WRITE_ENABLE_GATE]            = write_enable_gate_q;
    ctl[FPE_BIT_SEQERR]          = q.seq_err;
    ctl[FPE_BIT_LVERR]           = q.lv_err;
    ctl[FPE_BIT_LVSTAT]          = lv_act; // [R7]
    ctl[FPE_OP_MSB:FPE_OP_LSB]   = q.op_code; // [R16]

    // Protection check picks the scope of the chosen operation
    unique case (q.op_code)
      FPE_OP_ARRAY_ERASE: blocked = any_protected_i; // [R10]
      FPE_OP_PAGE_ERASE:  blocked = page_protected_i; // [R11]
      FPE_OP_ROW_PROG:    blocked = page_protected_i; // [R12]
      FPE_OP_WORD_PROG:   blocked = page_protected_i; // [R13]
      default:            blocked = 1'b0;
    endcase

    unique case (q.state)
      FPE_IDLE: begin
        if (q.trigger) begin
          if (q.op_code == FPE_OP_NOP) begin
            d.seq_err = 1'b0; // [R8]
            d.lv_err  = 1'b0; // [R8]
            d.state   = FPE_FIN;
          end else if (fpe_real_op(q.op_code) && !blocked) begin
            d.start = 1'b1; // [R2]
            d.state = FPE_RUN;
          end else if (fpe_real_op(q.op_code)) begin
            // Protected target: nothing is touched, the attempt is reported
            d.seq_err = 1'b1; // [R5]
            d.state   = FPE_FIN;
          end else begin
            d.state = FPE_FIN; // [R20]
          end
        end
      end
      FPE_RUN: begin
        if (flash_done_i) begin
          if (flash_fail_i) begin
            d.seq_err = 1'b1; // [R5]
          end
          d.state = FPE_FIN;
        end
      end
      FPE_FIN: begin
        d.trigger = 1'b0; // [R2]
        d.state   = FPE_IDLE;
      end
      default: d.state = FPE_IDLE;
    endcase

    // Writes outside the map are dropped rather than aliased onto the low byte
    if (acc_wr && fpe_mapped(paddr_i)) begin
      unique case (paddr_i[7:0])
        FPE_OFS_CONTROL: begin
          write_enable_gate_d = pwdata_i[FPE_BIT_WRITE_ENABLE_GATE]; // [R3]
          if (!write_enable_gate_q) begin
            d.op_code = pwdata_i[FPE_OP_MSB:FPE_OP_LSB]; // [R9]
          end
          if (pwdata_i[FPE_BIT_TRIGGER] && write_enable_gate_q && (q.key_stage == FPE_KEY_OPEN) &&
              !q.trigger && (q.state == FPE_IDLE)) begin
            d.trigger = 1'b1; // [R1]
          end
          // One unlock buys one control write
          d.key_stage = FPE_KEY_NONE; // [R15]
        end
        FPE_OFS_KEY: begin
          if ((q.key_stage == FPE_KEY_NONE) && (pwdata_i == UNLOCK_KEY_FIRST)) begin
            d.key_stage = FPE_KEY_FIRST; // [R15]
          end else if ((q.key_stage == FPE_KEY_FIRST) &&
                       (pwdata_i == UNLOCK_KEY_SECOND)) begin
            d.key_stage = FPE_KEY_OPEN; // [R15]
          end else begin
            d.key_stage = FPE_KEY_NONE;
          end
        end
        FPE_OFS_TARGET: d.target_addr  = pwdata_i;
        FPE_OFS_PWORD:  d.program_word = pwdata_i;
        FPE_OFS_ROWSRC: d.row_src      = pwdata_i;
        default: ;
      endcase
    end

    // Hardware sets come last so that a set beats a same-cycle clear
    if (lv_act) begin
      d.lv_err = 1'b1; // [R6]
      if (q.state == FPE_RUN) begin
        d.seq_err = 1'b1; // [R6]
      end
    end

    // Read data is captured in the setup phase, ready for the access phase
    if (rd_setup && !fpe_mapped(paddr_i)) begin
      d.rdata = 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr_i[7:0])
        FPE_OFS_CONTROL: d.rdata = ctl;
        FPE_OFS_TARGET:  d.rdata = q.target_addr;
        FPE_OFS_PWORD:   d.rdata = q.program_word;
        FPE_OFS_ROWSRC:  d.rdata = q.row_src;
        default:         d.rdata = 32'h0000_0000; // [R14]
      endcase
    end
  end

  // Power-on reset clears everything; device reset only the write enable gate
  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      q <= '{state: FPE_IDLE, trigger: 1'b0, seq_err: 1'b0, lv_err: 1'b0,
             op_code: FPE_RST_OP, target_addr: FPE_RST_WORD,
             program_word: FPE_RST_WORD, row_src: FPE_RST_WORD, // [R19]
             key_stage: FPE_KEY_NONE, rdata: FPE_RST_WORD, start: 1'b0,
             lv_s1: 1'b0, lv_s2: 1'b0};
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i or posedge por_i) begin
    if (rst_i || por_i) begin
      write_enable_gate_q <= 1'b0; // [R4]
    end else begin
      write_enable_gate_q <= write_enable_gate_d;
    end
  end

  assign prdata_o             = q.rdata;
  assign pready_o             = 1'b1;
  assign pslverr_o            = psel_i && penable_i && !fpe_mapped(paddr_i);
  assign flash_start_o        = q.start;
  assign flash_op_o           = q.op_code;
  // Array erase has no target, so the address is masked off
  assign flash_addr_o         = (q.op_code == FPE_OP_ARRAY_ERASE) ? 32'h0000_0000
                                : q.target_addr; // [R17]
  assign flash_data_o         = q.program_word;
  assign row_source_address_o = q.row_src; // [R18]
  assign detector_enable_o    = write_enable_gate_q; // [R3]

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (por_i || rst_i);

  // Sequencer and flag checks; either reset pauses them
  trig_needs_unlock_a: assert property ($rose(q.trigger) |-> // [R1]
    $past(write_enable_gate_q) && $past(q.key_stage) == FPE_KEY_OPEN)
    else $error("trigger set without enable and unlock");
  trig_idle_set_a: assert property ($rose(q.trigger) |-> // [R1]
    $past(q.state) == FPE_IDLE)
    else $error("trigger set while sequencer busy");
  trig_held_run_a: assert property ((q.state == FPE_RUN) |-> q.trigger) // [R2]
    else $error("trigger low during operation");
  trig_clears_a: assert property ((q.state == FPE_RUN) && flash_done_i |-> ##2 !q.trigger) // [R2]
    else $error("trigger not cleared after done");
  fin_one_cycle_a: assert property ((q.state == FPE_FIN) |=> // [R2]
    (q.state == FPE_IDLE) && !q.trigger)
    else $error("finish state did not return to idle");
  start_pulse_a: assert property (flash_start_o |=> !flash_start_o) // [R2]
    else $error("start pulse longer than one cycle");
  start_blocked_a: assert property (flash_start_o |-> !$past(blocked_chk)) // [R10]
    else $error("operation started on protected target");
  prot_reports_a: assert property ((q.state == FPE_IDLE) && q.trigger && // [R11]
    fpe_real_op(q.op_code) && blocked_chk |=> q.seq_err && !flash_start_o)
    else $error("protected target not reported");
  start_real_op_a: assert property (flash_start_o |-> // [R20]
    fpe_real_op(flash_op_o) && q.trigger)
    else $error("start for a code that touches no flash");
  seq_err_cause_a: assert property ($rose(q.seq_err) |-> $past(q.trigger)) // [R5]
    else $error("sequence error without an operation");
  nop_clears_a: assert property ((q.state == FPE_IDLE) && q.trigger && // [R8]
    q.op_code == FPE_OP_NOP && !lv_act |=> !q.seq_err && !q.lv_err)
    else $error("flags not cleared by no-operation");
  flag_clear_cause_a: assert property ($fell(q.seq_err) || $fell(q.lv_err) |-> // [R8]
    $past(q.trigger) && ($past(q.op_code) == FPE_OP_NOP))
    else $error("flag cleared without no-operation");
  op_locked_a: assert property ($past(write_enable_gate_q) |-> $stable(q.op_code)) // [R9]
    else $error("operation code changed while enabled");
  lv_flag_a: assert property (lv_act |=> q.lv_err) // [R6]
    else $error("low-voltage error not flagged");
  lv_err_cause_a: assert property ($rose(q.lv_err) |-> $past(lv_act)) // [R6]
    else $error("low-voltage error without active detector");
  nop_no_start_a: assert property ((q.state == FPE_IDLE) && q.trigger && // [R20]
    !fpe_real_op(q.op_code) |=> !flash_start_o ##1 !q.trigger)
    else $error("no-operation touched flash");

  // Readback is captured at setup, so the word is checked one cycle on
  key_read_zero_a: assert property (rd_setup && paddr_i == {24'h0, FPE_OFS_KEY} // [R14]
    |=> prdata_o == 32'h0000_0000)
    else $error("key register read back nonzero");
  ctl_unimpl_zero_a: assert property (rd_setup && paddr_i == {24'h0, FPE_OFS_CONTROL} // [R16]
    |=> prdata_o[31:16] == 16'h0000 && prdata_o[10:4] == 7'h00)
    else $error("unimplemented control bits read nonzero");
  lv_status_gated_a: assert property (rd_setup && !write_enable_gate_q && // [R7]
    paddr_i == {24'h0, FPE_OFS_CONTROL} |=> !prdata_o[FPE_BIT_LVSTAT])
    else $error("low-voltage status shown with detector off");
  unmapped_drop_a: assert property (acc_wr && !fpe_mapped(paddr_i) |=> // [R16]
    $stable(q.target_addr) && $stable(q.program_word) && $stable(q.row_src))
    else $error("write outside the map changed a register");
  pword_kept_a: assert property ($changed(q.program_word) |-> // [R19]
    $past(acc_wr) && $past(paddr_i) == {24'h0, FPE_OFS_PWORD})
    else $error("program word changed without a write");
  unlock_once_a: assert property (acc_wr && paddr_i == {24'h0, FPE_OFS_CONTROL} |=> // [R15]
    q.key_stage == FPE_KEY_NONE)
    else $error("unlock survived a control write");

  // Covers mark the paths the bench is meant to reach
  op_run_c: cover property (flash_start_o ##[1:50] flash_done_i);
  nop_clear_c: cover property (q.seq_err ##[1:50] !q.seq_err);
  lv_event_c: cover property ($rose(q.lv_err));
  prot_block_c: cover property (q.trigger && blocked_chk && fpe_real_op(q.op_code) ##1 q.seq_err);
  lv_live_c: cover property (lv_act ##[1:20] !lv_act);

endmodule

/* File: testbench/fpe_flash_ctrl_test.sv */
// Self-checking bench for fpe_flash_ctrl: APB master tasks, flash macro stand-in.
// Assumes a zero-wait APB slave and one 100 MHz clock; values from a fixed LFSR.
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module fpe_flash_ctrl_test;
  import fpe_pkg::*;
  localparam logic [31:0] K1    = 32'hA5C3_0F1E; // Arbitrary unlock value
  localparam logic [31:0] K2    = 32'h3C5A_E1F0; // Arbitrary unlock value
  localparam logic [31:0] A_CTL = {24'h0, FPE_OFS_CONTROL};
  localparam logic [31:0] A_KEY = {24'h0, FPE_OFS_KEY};
  localparam logic [31:0] A_TGT = {24'h0, FPE_OFS_TARGET};
  localparam logic [31:0] A_PW  = {24'h0, FPE_OFS_PWORD};
  localparam logic [31:0] A_ROW = {24'h0, FPE_OFS_ROWSRC};
  logic        clk_i, rst_i, por_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic        low_voltage_i, page_protected_i, any_protected_i, flash_done_i;
  logic        flash_fail_i, flash_start_o, detector_enable_o, rerr, err;
  logic [3:0]  flash_op_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, flash_addr_o, flash_data_o;
  logic [31:0] row_source_address_o, rdat, seed, tgt, pw;
  int          bad_count, checked, starts, cycles;

  fpe_flash_ctrl #(.UNLOCK_KEY_FIRST(K1), .UNLOCK_KEY_SECOND(K2)) u_fpe_flash_ctrl (
    .clk_i, .rst_i, .por_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .low_voltage_i, .page_protected_i,
    .any_protected_i, .flash_done_i, .flash_fail_i, .flash_start_o, .flash_op_o,
    .flash_addr_o, .flash_data_o, .row_source_address_o, .detector_enable_o);

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard: the whole run needs about seven hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (flash_start_o === 1'b1) starts++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
  endfunction

  // Expected control word once an operation is over: gate up, trigger down
  function automatic logic [31:0] exp_ctl(input logic err_f, input logic [3:0] op);
    return {16'h0, 2'b01, err_f, 9'h0, op};
  endfunction

  task automatic results;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Only the bench's cycle ceiling ends a wait for ready
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // Gate low twice: the first write only drops the gate, the second loads the code
  task automatic run_op(input logic [3:0] op, input logic prot, fail);
    int   n0;
    logic go;
    go = (op inside {4'h1, 4'h3, 4'h4, 4'h5}) && !prot;
    wr(A_CTL, {28'h0, op});
    wr(A_CTL, {28'h0, op});
    wr(A_CTL, {16'h0, 2'b01, 10'h0, op});
    wr(A_KEY, K1);
    wr(A_KEY, K2);
    // The input outside the operation's scope is random and must not matter
    page_protected_i <= (op == 4'h5) ? seed[2] : prot;
    any_protected_i  <= (op == 4'h5) ? prot : seed[2];
    n0 = starts;
    wr(A_CTL, {16'h0, 2'b11, 10'h0, op});
    if (go) begin
      rd(A_CTL);
      `CHK(rdat[15], 1'b1)
      `CHK(flash_op_o, op)
      `CHK(flash_addr_o, (op == 4'h5) ? 32'h0 : tgt)
      flash_fail_i <= fail;
      flash_done_i <= 1'b1;
      @(posedge clk_i);
      flash_done_i <= 1'b0;
    end
    repeat (6) @(posedge clk_i);
    `CHK(starts - n0, go ? 1 : 0)
    err = (op == 4'h0) ? 1'b0 : (err | prot | (go & fail));
    rd(A_CTL);
    `CHK(rdat, exp_ctl(err, op))
  endtask

  initial begin
    {rst_i, por_i} = 2'b11;
    {psel_i, penable_i, pwrite_i, low_voltage_i, page_protected_i} = '0;
    {any_protected_i, flash_done_i, flash_fail_i} = '0;
    {paddr_i, pwdata_i} = '0;
    seed = 32'h20C0;
    err = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    rd(A_CTL);
    `CHK(rdat, 32'h0)
    tgt = lfsr_next(seed);
    pw = lfsr_next(tgt);
    seed = lfsr_next(pw);
    wr(A_TGT, tgt);
    wr(A_PW, pw);
    wr(A_ROW, seed);
    `CHK(flash_data_o, pw)
    wr(A_KEY, K1);
    // The row source write lands at the edge the task returns on, so look one write later
    `CHK(row_source_address_o, seed)
    rd(A_KEY);
    `CHK(rdat, 32'h0)
    rd(32'h0000_0040);
    `CHK({rerr, rdat}, 33'h1_0000_0000)
    // Trigger in the same word as the gate is refused: the gate was still low
    wr(A_CTL, 32'hFFFF_C7F5);
    rd(A_CTL);
    `CHK(rdat, 32'h0000_4005)
    wr(A_CTL, 32'h0000_4003);
    wr(A_CTL, 32'h0000_C005);
    rd(A_CTL);
    `CHK(rdat, 32'h0000_4005)
    wr(A_CTL, 32'h0000_0005);
    wr(A_KEY, K1);
    wr(A_KEY, K2);
    wr(A_CTL, 32'h0000_8005);
    rd(A_CTL);
    `CHK(rdat, 32'h0000_0005)
    for (int i = 0; i < 16; i++) begin
      seed = lfsr_next(seed);
      run_op(i[3:0], seed[0] & (i[3:0] inside {4'h1, 4'h3, 4'h4, 4'h5}), seed[1]);
    end
    run_op(4'h5, 1'b1, 1'b0);
    run_op(4'h5, 1'b0, 1'b0);
    run_op(4'h1, 1'b0, 1'b1);
    run_op(4'h0, 1'b0, 1'b0);
    `CHK(detector_enable_o, 1'b1)
    low_voltage_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rd(A_CTL);
    `CHK(rdat[12:11], 2'b11)
    low_voltage_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(A_CTL);
    `CHK(rdat[12:11], 2'b10)
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_CTL);
    `CHK(rdat, 32'h0000_1000)
    `CHK(detector_enable_o, 1'b0)
    rd(A_TGT);
    `CHK(rdat, tgt)
    low_voltage_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rd(A_CTL);
    `CHK(rdat[12:11], 2'b10)
    low_voltage_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    run_op(4'h0, 1'b0, 1'b0);
    rd(A_PW);
    `CHK(rdat, pw)
    por_i <= 1'b1;
    @(posedge clk_i);
    por_i <= 1'b0;
    rd(A_PW);
    `CHK(rdat, 32'h0)
    results();
  end
endmodule
